//--- verilog/fxc_defines.svh
`ifndef FXC_DEFINES_SVH
`define FXC_DEFINES_SVH

// ==========================================================
// Segment selectors (system address bits 31:24)
`define FXC_SEG_CA 8'h10
`define FXC_SEG_CN 8'h11
`define FXC_SEG_NA 8'h12
`define FXC_SEG_NN 8'h13
`define FXC_SEG_SRAM 8'h15

// ==========================================================
// Register byte offsets on APB
`define FXC_OFF_CTRL 12'h000
`define FXC_OFF_FLUSH 12'h004
`define FXC_OFF_STAT 12'h008
`define FXC_OFF_STREAM_ADDR 12'h014
`define FXC_OFF_STREAM_CTR 12'h018
`define FXC_OFF_STREAM_FIFO 12'h01c

// ==========================================================
// Control register fields
`define FXC_CTRL_EN 0
`define FXC_CTRL_LANES_LO 4
`define FXC_CTRL_LANES_HI 5
`define FXC_CTRL_USE_CMD 6
`define FXC_CTRL_CMD_LO 8
`define FXC_CTRL_CMD_HI 15
`define FXC_CTRL_DIV_LO 16
`define FXC_CTRL_DIV_HI 19
`define FXC_FLUSH_GO 0
`define FXC_STAT_FLUSH_READY 0
`define FXC_STAT_FIFO_EMPTY 1
`define FXC_STAT_FIFO_FULL 2

// ==========================================================
// Reset values and limits
`define FXC_RST_EN 1'b1
`define FXC_RST_LANES 2'h0
`define FXC_RST_USE_CMD 1'b1
`define FXC_RST_CMD 8'h03
`define FXC_RST_DIV 4'h2
`define FXC_MIN_DIV 4'h2
`define FXC_LANES_MAX 2'h2
`define FXC_LAST_SET 10'h3ff
`define FXC_FIFO_DEPTH 2'h2
`define FXC_WORD_BYTES 24'h000004

`endif

//--- verilog/fxc_pkg.sv
`include "fxc_defines.svh"

package fxc_pkg;

    // ==========================================================
    // Controller states
    typedef enum logic [2:0] {
        FXC_FLUSH,
        FXC_IDLE,
        FXC_FETCH,
        FXC_SRAMW,
        FXC_DONE
    } fxc_state_t;

    // ==========================================================
    // Whole register state of the block
    typedef struct packed {
        fxc_state_t state;
        logic [9:0] flush_cnt;
        logic flush_pend;
        logic en;
        logic [1:0] lanes;
        logic use_cmd;
        logic [7:0] cmd;
        logic [3:0] clkdiv;
        logic sys_ready;
        logic sys_err;
        logic [31:0] sys_rdata;
        logic prev_sram_wr;
        logic fetch_stream;
        logic fetch_alloc;
        logic fl_req;
        logic [23:0] fl_addr;
        logic [2:0] cool;
        logic [23:0] str_addr;
        logic [23:0] str_cnt;
        logic [1:0][31:0] fifo;
        logic fifo_rd;
        logic [1:0] fifo_cnt;
        logic [31:0] aux_rdata;
        logic dreq;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } fxc_regs_t;

    localparam fxc_regs_t FXC_RESET = '{
        state: FXC_FLUSH,
        en: `FXC_RST_EN,
        lanes: `FXC_RST_LANES,
        use_cmd: `FXC_RST_USE_CMD,
        cmd: `FXC_RST_CMD,
        clkdiv: `FXC_RST_DIV,
        default: '0
    };

endpackage

//--- verilog/fxc_top.sv
// Functional notes
// - 16 kB two-way set-associative read cache, hit answered one cycle later.
// - Address bits 31:24 pick segment; bits 23:0 address flash, 16 MB.
// - Segment 0x10 reads look up, and on miss fetch and allocate.
// - Segment 0x11 reads look up but never allocate on miss.
// - Segment 0x12 reads skip lookup, always fetch and allocate.
// - Segment 0x13 accesses bypass the cache entirely.
// - Cache disabled: all four flash segments go straight to flash.
// - Segment 0x15 answers bus error while cache enabled.
// - Cache disabled: data memory is 16 kB SRAM mirrored over 0x15.
// - SRAM read straight after SRAM write gets one wait state.
// - Flush starts on writing 1 to flush trigger and after reset.
// - Flush clears tags set by set, 1024 cycles; data kept.
// - Flash accesses during flush wait until it completes.
// - Write to 0x10 with cache enabled invalidates the matching cache line.
// - Link supports 1, 2 or 4 lines, command prefix or continuation.
// - Serial flash clock at most half the system clock.
// - Programming stream address and count launches background reads.
// - Stream reads yield to regular bus master flash accesses.
// - Stream resumes only seven cycles after last miss served.
// - Streamed words enter FIFO; DMA request only when data present.
// - Auxiliary port reads FIFO only, without wait states.
// - FIFO two deep, reports full and empty, empty after reset.
// - Reading flush trigger stalls the bus until flush done.
// - Flush-ready flag reads 0 during flush, 1 otherwise.
//
// Local design decisions: the register addresses and the APB register port.
`include "fxc_defines.svh"
module fxc_top
    import fxc_pkg::*;
#(
    parameter int STREAM_COOLDOWN = 7
) (
    input wire logic pclk,
    input wire logic presetn,
    // APB register slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // System bus port for the flash and SRAM segments
    input wire logic sys_valid,
    input wire logic sys_write,
    input wire logic [31:0] sys_addr,
    input wire logic [31:0] sys_wdata,
    output logic sys_ready,
    output logic sys_err,
    output logic [31:0] sys_rdata,
    // Request port toward the serial_flash_interface
    output logic fl_req,
    output logic [23:0] fl_addr,
    output logic [1:0] fl_lanes,
    output logic fl_use_cmd,
    output logic [7:0] fl_cmd,
    output logic [3:0] fl_clk_div,
    input wire logic fl_done,
    input wire logic [63:0] fl_rdata,
    // Auxiliary zero-wait FIFO port and DMA request
    input wire logic aux_rd,
    output logic [31:0] aux_rdata,
    output logic dreq
);

    // ==========================================================
    // Elaboration checks
    if (STREAM_COOLDOWN < 1 || STREAM_COOLDOWN > 7) begin : g_cool_check
        $error("STREAM_COOLDOWN must lie in 1..7");
    end

    localparam logic [2:0] COOL_INIT = 3'(STREAM_COOLDOWN);

    // ==========================================================
    // Helpers
    function automatic logic fxc_match(input logic [11:0] entry, input logic [10:0] tag);
        return entry[11] && (entry[10:0] == tag);
    endfunction

    function automatic logic [31:0] fxc_word(input logic [63:0] line, input logic upper);
        return upper ? line[63:32] : line[31:0];
    endfunction

    // ==========================================================
    // Storage: tags with valid bit, data halves, replacement bits
    logic [11:0] tag0 [0:1023];
    logic [11:0] tag1 [0:1023];
    logic [31:0] dlo [0:2047];
    logic [31:0] dhi [0:2047];
    logic lru [0:1023];

    fxc_regs_t q;
    fxc_regs_t next_q;

    logic [1:0] t_we;
    logic [9:0] t_idx;
    logic [11:0] t_val;
    logic d_we_lo;
    logic d_we_hi;
    logic [10:0] d_idx;
    logic [31:0] d_lo;
    logic [31:0] d_hi;
    logic l_we;
    logic [9:0] l_idx;
    logic l_val;
    logic push;
    logic [31:0] push_data;
    logic pop;
    logic victim;
    logic slot;

    // Address split of the current system request
    logic [7:0] seg;
    logic [23:0] fa;
    logic [9:0] set_i;
    logic [10:0] tag_i;
    logic h0;
    logic h1;
    logic [63:0] line0;
    logic [63:0] line1;
    logic [31:0] sram_word;
    logic is_flash;
    logic cacheable;
    logic alloc;
    logic flushing;
    logic apb_acc;
    logic stream_go;

    assign seg = sys_addr[31:24];
    assign fa = sys_addr[23:0];
    assign set_i = fa[12:3];
    assign tag_i = fa[23:13];
    assign h0 = fxc_match(tag0[set_i], tag_i);
    assign h1 = fxc_match(tag1[set_i], tag_i);
    assign line0 = {dhi[{1'b0, set_i}], dlo[{1'b0, set_i}]};
    assign line1 = {dhi[{1'b1, set_i}], dlo[{1'b1, set_i}]};
    assign sram_word = fa[2] ? dhi[fa[13:3]] : dlo[fa[13:3]];
    assign is_flash = (seg == `FXC_SEG_CA) || (seg == `FXC_SEG_CN) || (seg == `FXC_SEG_NA) ||
        (seg == `FXC_SEG_NN);
    // Disabled cache turns every flash segment into a bypass
    assign cacheable = q.en && (seg == `FXC_SEG_CA || seg == `FXC_SEG_CN);
    assign alloc = q.en && (seg == `FXC_SEG_CA || seg == `FXC_SEG_NA);
    assign flushing = (q.state == FXC_FLUSH) || q.flush_pend;
    assign apb_acc = psel && penable;
    // Stream only starts from idle with no master waiting
    assign stream_go = (q.str_cnt != '0) && (q.fifo_cnt != `FXC_FIFO_DEPTH) && (q.cool == '0);
    // Refill way: reuse a matching way so a line never sits twice
    assign victim = h1 ? 1'b1 : (h0 ? 1'b0 : lru[set_i]);

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_q = q;
        next_q.sys_ready = 1'b0;
        next_q.sys_err = 1'b0;
        t_we = '0;
        t_idx = set_i;
        t_val = '0;
        d_we_lo = 1'b0;
        d_we_hi = 1'b0;
        d_idx = {1'b0, set_i};
        d_lo = sys_wdata;
        d_hi = sys_wdata;
        l_we = 1'b0;
        l_idx = set_i;
        l_val = 1'b0;
        push = 1'b0;
        push_data = '0;
        pop = 1'b0;
        slot = 1'b0;
        if (q.cool != '0) begin
            next_q.cool = q.cool - 3'h1;
        end

        unique case (q.state)
            FXC_FLUSH: begin
                // Both ways of one set per cycle; data memory left alone
                t_we = 2'b11;
                t_idx = q.flush_cnt;
                if (q.flush_cnt == `FXC_LAST_SET) begin
                    next_q.state = FXC_IDLE;
                end else begin
                    next_q.flush_cnt = q.flush_cnt + 10'h001;
                end
            end
            FXC_IDLE: begin
                if (q.flush_pend) begin
                    next_q.state = FXC_FLUSH;
                    next_q.flush_cnt = '0;
                    next_q.flush_pend = 1'b0;
                end else if (sys_valid) begin
                    next_q.prev_sram_wr = 1'b0;
                    if (is_flash) begin
                        if (sys_write) begin
                            // Writes elsewhere are accepted and dropped
                            if (seg == `FXC_SEG_CA && q.en) begin
                                t_we = {h1, h0};
                            end
                            next_q.sys_ready = 1'b1;
                            next_q.state = FXC_DONE;
                        end else if (cacheable && (h0 || h1)) begin
                            next_q.sys_rdata = fxc_word(h1 ? line1 : line0, fa[2]);
                            next_q.sys_ready = 1'b1;
                            next_q.state = FXC_DONE;
                            l_we = 1'b1;
                            l_val = h0;
                        end else begin
                            next_q.fl_req = 1'b1;
                            next_q.fl_addr = {fa[23:3], 3'h0};
                            next_q.fetch_stream = 1'b0;
                            next_q.fetch_alloc = alloc;
                            next_q.state = FXC_FETCH;
                        end
                    end else if (seg == `FXC_SEG_SRAM && !q.en) begin
                        if (sys_write) begin
                            d_idx = fa[13:3];
                            d_we_lo = !fa[2];
                            d_we_hi = fa[2];
                            next_q.prev_sram_wr = 1'b1;
                            next_q.sys_ready = 1'b1;
                            next_q.state = FXC_DONE;
                        end else if (q.prev_sram_wr) begin
                            // No forwarding path, so give the array a cycle
                            next_q.state = FXC_SRAMW;
                        end else begin
                            next_q.sys_rdata = sram_word;
                            next_q.sys_ready = 1'b1;
                            next_q.state = FXC_DONE;
                        end
                    end else begin
                        next_q.sys_err = 1'b1;
                        next_q.sys_ready = 1'b1;
                        next_q.state = FXC_DONE;
                    end
                end else if (stream_go) begin
                    next_q.fl_req = 1'b1;
                    next_q.fl_addr = {q.str_addr[23:3], 3'h0};
                    next_q.fetch_stream = 1'b1;
                    next_q.state = FXC_FETCH;
                end
            end
            FXC_FETCH: begin
                if (fl_done) begin
                    next_q.fl_req = 1'b0;
                    if (q.fetch_stream) begin
                        push = 1'b1;
                        push_data = fxc_word(fl_rdata, q.str_addr[2]);
                        next_q.str_addr = q.str_addr + `FXC_WORD_BYTES;
                        next_q.str_cnt = q.str_cnt - 24'h000001;
                        next_q.state = FXC_IDLE;
                    end else begin
                        if (q.fetch_alloc) begin
                            t_we = victim ? 2'b10 : 2'b01;
                            t_val = {1'b1, tag_i};
                            d_idx = {victim, set_i};
                            d_lo = fl_rdata[31:0];
                            d_hi = fl_rdata[63:32];
                            d_we_lo = 1'b1;
                            d_we_hi = 1'b1;
                            l_we = 1'b1;
                            l_val = !victim;
                        end
                        next_q.sys_rdata = fxc_word(fl_rdata, fa[2]);
                        next_q.sys_ready = 1'b1;
                        next_q.cool = COOL_INIT;
                        next_q.state = FXC_DONE;
                    end
                end
            end
            FXC_SRAMW: begin
                next_q.sys_rdata = sram_word;
                next_q.sys_ready = 1'b1;
                next_q.state = FXC_DONE;
            end
            FXC_DONE: begin
                // Master drops its request in this cycle
                next_q.state = FXC_IDLE;
            end
        endcase

        // APB: one wait state, then completion edge applies writes
        next_q.pready = 1'b0;
        if (apb_acc && !q.pready) begin
            if (!(paddr == `FXC_OFF_FLUSH && !pwrite && flushing)) begin
                next_q.pready = 1'b1;
                next_q.pslverr = 1'b0;
                next_q.prdata = '0;
                unique case (paddr)
                    `FXC_OFF_CTRL: begin
                        next_q.prdata[`FXC_CTRL_EN] = q.en;
                        next_q.prdata[`FXC_CTRL_LANES_HI:`FXC_CTRL_LANES_LO] = q.lanes;
                        next_q.prdata[`FXC_CTRL_USE_CMD] = q.use_cmd;
                        next_q.prdata[`FXC_CTRL_CMD_HI:`FXC_CTRL_CMD_LO] = q.cmd;
                        next_q.prdata[`FXC_CTRL_DIV_HI:`FXC_CTRL_DIV_LO] = q.clkdiv;
                    end
                    `FXC_OFF_FLUSH: begin
                    end
                    `FXC_OFF_STAT: begin
                        next_q.prdata[`FXC_STAT_FLUSH_READY] = !flushing;
                        next_q.prdata[`FXC_STAT_FIFO_EMPTY] = (q.fifo_cnt == '0);
                        next_q.prdata[`FXC_STAT_FIFO_FULL] = (q.fifo_cnt == `FXC_FIFO_DEPTH);
                    end
                    `FXC_OFF_STREAM_ADDR: next_q.prdata[23:0] = q.str_addr;
                    `FXC_OFF_STREAM_CTR: next_q.prdata[23:0] = q.str_cnt;
                    `FXC_OFF_STREAM_FIFO: next_q.prdata = q.fifo[q.fifo_rd];
                    default: next_q.pslverr = 1'b1;
                endcase
            end
        end else if (apb_acc && q.pready) begin
            if (pwrite) begin
                unique case (paddr)
                    `FXC_OFF_CTRL: begin
                        next_q.en = pwdata[`FXC_CTRL_EN];
                        // Four lines is the widest link; reserved code clamps
                        next_q.lanes = (pwdata[`FXC_CTRL_LANES_HI:`FXC_CTRL_LANES_LO] > `FXC_LANES_MAX) ?
                            `FXC_LANES_MAX : pwdata[`FXC_CTRL_LANES_HI:`FXC_CTRL_LANES_LO];
                        next_q.use_cmd = pwdata[`FXC_CTRL_USE_CMD];
                        next_q.cmd = pwdata[`FXC_CTRL_CMD_HI:`FXC_CTRL_CMD_LO];
                        next_q.clkdiv = (pwdata[`FXC_CTRL_DIV_HI:`FXC_CTRL_DIV_LO] < `FXC_MIN_DIV) ?
                            `FXC_MIN_DIV : pwdata[`FXC_CTRL_DIV_HI:`FXC_CTRL_DIV_LO];
                    end
                    `FXC_OFF_FLUSH: begin
                        if (pwdata[`FXC_FLUSH_GO]) begin
                            next_q.flush_pend = 1'b1;
                        end
                    end
                    `FXC_OFF_STREAM_ADDR: next_q.str_addr = {pwdata[23:2], 2'h0};
                    `FXC_OFF_STREAM_CTR: next_q.str_cnt = pwdata[23:0];
                    default: begin
                    end
                endcase
            end else if (paddr == `FXC_OFF_STREAM_FIFO) begin
                pop = 1'b1;
            end
        end

        // Stream FIFO, two entries
        if (aux_rd) begin
            pop = 1'b1;
        end
        if (pop && q.fifo_cnt != '0) begin
            next_q.fifo_rd = !q.fifo_rd;
            next_q.fifo_cnt = next_q.fifo_cnt - 2'h1;
        end
        if (push) begin
            slot = q.fifo_rd ^ q.fifo_cnt[0];
            next_q.fifo[slot] = push_data;
            next_q.fifo_cnt = next_q.fifo_cnt + 2'h1;
        end
        // Head is always staged, so the auxiliary read never waits
        next_q.aux_rdata = next_q.fifo[next_q.fifo_rd];
        next_q.dreq = (next_q.fifo_cnt != '0);
    end

    // ==========================================================
    // State register; reset lands in flush
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= FXC_RESET;
        end else begin
            q <= next_q;
        end
    end

    // ==========================================================
    // Memory arrays, no reset: tags are cleared by the flush
    always_ff @(posedge pclk) begin
        if (t_we[0]) begin
            tag0[t_idx] <= t_val;
        end
        if (t_we[1]) begin
            tag1[t_idx] <= t_val;
        end
        if (d_we_lo) begin
            dlo[d_idx] <= d_lo;
        end
        if (d_we_hi) begin
            dhi[d_idx] <= d_hi;
        end
        if (l_we) begin
            lru[l_idx] <= l_val;
        end
    end

    // ==========================================================
    // Outputs straight from the state register
    assign pready = q.pready;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr;
    assign sys_ready = q.sys_ready;
    assign sys_err = q.sys_err;
    assign sys_rdata = q.sys_rdata;
    assign fl_req = q.fl_req;
    assign fl_addr = q.fl_addr;
    assign fl_lanes = q.lanes;
    assign fl_use_cmd = q.use_cmd;
    assign fl_cmd = q.cmd;
    assign fl_clk_div = q.clkdiv;
    assign aux_rdata = q.aux_rdata;
    assign dreq = q.dreq;

endmodule

//--- test/fxc_props.sv
module fxc_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic sys_valid,
    input wire logic [31:0] sys_addr,
    input wire logic sys_ready,
    input wire logic sys_err,
    input wire logic fl_req,
    input wire logic [23:0] fl_addr,
    input wire logic fl_done,
    input wire logic [1:0] fl_lanes,
    input wire logic [3:0] fl_clk_div,
    input wire logic dreq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Port checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [10:0] since_rst, apb_wait;
    // Cycles since reset; access cycles unanswered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_rst <= 11'h000;
            apb_wait <= 11'h000;
        end else begin
            apb_wait <= (psel && penable && !pready) ? apb_wait + 11'h001 : 11'h000;
            since_rst <= since_rst + 11'(since_rst != 11'h7ff);
        end
    end
    sequence s_acc; psel && penable; endsequence
    sequence s_ans; apb_wait < 11'h44c; endsequence
    property p_apb_ans; s_acc |-> s_ans; endproperty
    property p_sys_pulse; sys_ready |=> !sys_ready; endproperty
    property p_bad_seg;
        sys_ready && sys_valid && !(sys_addr[31:24] inside {8'h10, 8'h11, 8'h12, 8'h13, 8'h15}) |-> sys_err;
    endproperty
    property p_flash_ok; sys_ready && sys_valid && sys_addr[31:26] == 6'h04 |-> !sys_err; endproperty
    property p_flush_wait; sys_ready |-> since_rst >= 11'h400; endproperty
    property p_fl_hold; fl_req && !fl_done |=> fl_req && $stable(fl_addr); endproperty
    property p_fl_drop; fl_done |=> !fl_req; endproperty
    property p_div; fl_clk_div >= 4'h2 && fl_lanes <= 2'h2; endproperty
    property p_dreq; $rose(dreq) |-> $past(fl_done) || $past(fl_done, 2); endproperty
    a_apb_ans: assert property (p_apb_ans) else $error("access not answered");
    a_sys_pulse: assert property (p_sys_pulse) else $error("system ready too long");
    a_bad_seg: assert property (p_bad_seg) else $error("unknown segment accepted");
    a_flash_ok: assert property (p_flash_ok) else $error("flash segment errored");
    a_flush_wait: assert property (p_flush_wait) else $error("answer during start-up flush");
    a_fl_hold: assert property (p_fl_hold) else $error("fetch request unstable");
    a_fl_drop: assert property (p_fl_drop) else $error("fetch request after done");
    a_div: assert property (p_div) else $error("link setting out of range");
    a_dreq: assert property (p_dreq) else $error("dma request without data");
endmodule

bind fxc_top fxc_props props_u (.*);

//--- test/fxc_flash_model.sv
module fxc_flash_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fl_req,
    input wire logic [23:0] fl_addr,
    input wire logic [1:0] fl_lanes,
    input wire logic fl_use_cmd,
    input wire logic [3:0] fl_clk_div,
    output logic fl_done,
    output logic [63:0] fl_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    logic [11:0] cnt;
    // ==========
    // Line fetch; slower with command prefix, few lanes or a big divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            cnt <= 12'h000;
            fl_done <= 1'b0;
            fl_rdata <= 64'h0;
        end else begin
            fl_done <= 1'b0;
            fl_rdata <= ~fl_rdata; // Data not held outside the answer
            if (fl_req && !busy && !fl_done) begin
                busy <= 1'b1;
                cnt <= ((fl_use_cmd ? 12'h060 : 12'h058) >> fl_lanes) * {8'h00, fl_clk_div};
            end else if (busy && cnt != 12'h000) begin
                cnt <= cnt - 12'h001;
            end else if (busy) begin
                busy <= 1'b0;
                fl_done <= 1'b1;
                fl_rdata <= {8'h5a, fl_addr, 8'ha5, fl_addr};
            end
        end
    end
endmodule

//--- test/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, kept = 1'b0;
    logic sys_valid = 1'b0, sys_write = 1'b0, aux_rd = 1'b0;
    logic pready, pslverr, sys_ready, sys_err, fl_req, fl_use_cmd, fl_done, dreq, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, sys_addr = 32'h0, sys_wdata = 32'h0, prdata, sys_rdata, aux_rdata, rd;
    logic [23:0] fl_addr;
    logic [1:0] fl_lanes;
    logic [7:0] fl_cmd;
    logic [3:0] fl_clk_div;
    logic [63:0] fl_rdata;
    int n_errors = 0, checked = 0, lat, lat_b, fetches = 0, f0, cyc = 0;
    // Rows: {write, fetch expected, error expected, address}
    localparam logic [34:0] ROWS [15] = '{35'h210000010, 35'h010000014, 35'h211000020, 35'h211000020,
        35'h212000010, 35'h212000030, 35'h011000034, 35'h213000010, 35'h213000040, 35'h210000040,
        35'h410000010, 35'h210000010, 35'h115000000, 35'h114000000, 35'h210ffff08};

    fxc_top dut_u (.*);
    fxc_flash_model flash_u (.*);

    // ==========
    // Clock, fetch count, hang guard
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        fetches += (fl_done === 1'b1);
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            test_done();
        end
    end

    function automatic logic [31:0] fw(input logic [31:0] a);
        return {a[2] ? 8'h5a : 8'ha5, a[23:3], 3'b000};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        if (n_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Register access, held until ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        lat = 0;
        do begin
            @(posedge pclk);
            lat++;
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        rd = prdata;
        er = pslverr;
    endtask

    // System access; keep leaves valid up so the next one follows at once
    task automatic sys_go(input logic w, input logic [31:0] a, input logic [31:0] d, input logic keep);
        if (!kept) begin
            @(posedge pclk);
        end
        sys_valid <= 1'b1;
        sys_write <= w;
        sys_addr <= a;
        sys_wdata <= d;
        f0 = fetches;
        lat = 0;
        do begin
            @(posedge pclk);
            lat++;
        end while (sys_ready !== 1'b1);
        rd = sys_rdata;
        er = sys_err;
        kept = keep;
        if (!keep) begin
            sys_valid <= 1'b0;
        end
    endtask

    // Pop the auxiliary port once data is flagged
    task automatic pop(input logic [31:0] exp);
        repeat (2) @(posedge pclk);
        wait (dreq === 1'b1);
        aux_rd <= 1'b1;
        @(posedge pclk);
        aux_rd <= 1'b0;
        chk(aux_rdata, exp);
    endtask

    // ==========
    // Main sequence
    initial begin
        repeat (12) @(posedge pclk);
        chk(32'({fl_cmd, fl_clk_div, fl_lanes, fl_use_cmd, dreq}), 32'h0322);
        presetn <= 1'b1;
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, 12'h00c, 32'h0);
        chk(32'(er), 32'h1);
        sys_go(1'b0, 32'h13000008, 32'h0, 1'b0);
        chk(32'(lat >= 1000), 32'h1);
        chk(rd, fw(32'h13000008));
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h000, 32'h301 | (i << 4) | ((i & 1) << 6));
            @(posedge pclk);
            chk({29'h0, fl_use_cmd, fl_lanes}, 32'((i & 1) << 2 | (i == 3 ? 2 : i)));
        end
        foreach (ROWS[i]) begin
            sys_go(ROWS[i][34], ROWS[i][31:0], 32'h0, 1'b0);
            chk(32'(er), 32'(ROWS[i][32]));
            chk(32'(fetches - f0), 32'(ROWS[i][33]));
            if (!ROWS[i][33]) begin
                chk(32'(lat), 32'h2);
            end
            if (!ROWS[i][34] && !ROWS[i][32]) begin
                chk(rd, fw(ROWS[i][31:0]));
            end
        end
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h2);
        sys_go(1'b0, 32'h10000040, 32'h0, 1'b0);
        chk(32'(lat >= 1000), 32'h1);
        chk(32'(fetches - f0), 32'h1);
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk(32'(lat >= 1000), 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, 12'h000, 32'h370);
        @(posedge pclk);
        chk({26'h0, fl_lanes, fl_clk_div}, 32'h22);
        sys_go(1'b0, 32'h15000010, 32'h0, 1'b1);
        sys_go(1'b0, 32'h15000010, 32'h0, 1'b1);
        lat_b = lat;
        sys_go(1'b1, 32'h15004010, 32'h1234abcd, 1'b1);
        chk(32'(er), 32'h0);
        sys_go(1'b0, 32'h15000010, 32'h0, 1'b0);
        chk(rd, 32'h1234abcd);
        chk(32'(lat), 32'(lat_b + 1));
        sys_go(1'b0, 32'h10000040, 32'h0, 1'b0);
        sys_go(1'b0, 32'h10000040, 32'h0, 1'b0);
        chk(32'(fetches - f0), 32'h1);
        apb(1'b1, 12'h000, 32'h361);
        apb(1'b1, 12'h014, 32'h100);
        apb(1'b1, 12'h018, 32'h3);
        for (int i = 0; i < 200 && rd !== 32'h5; i++) begin
            apb(1'b0, 12'h008, 32'h0);
        end
        chk(rd, 32'h5);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd, 32'h1);
        pop(32'ha5000100);
        pop(32'h5a000100);
        pop(32'ha5000108);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd, 32'h0);
        test_done();
    end
endmodule
